// File: hdl/usbdm_pkg.sv
// package for the usb descriptor dma mapping block: register map, field
// positions, reset values, descriptor layout and the index function.
// assumes a 32-bit ahb-lite register bus and a 32-bit system memory.
package usbdm_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
    localparam logic [7:0] OFS_CONFIG_TWO = 8'h04;
    localparam logic [7:0] OFS_TABLE_BASE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // config one fields
    localparam int EYE_BIT = 7;
    localparam int OEMON_BIT = 6;
    localparam int SIDL_BIT = 4;
    localparam int PINGPONG_LSB = 0;
    localparam logic [15:0] CONFIG_ONE_MASK = 16'h00D3;
    localparam logic [15:0] CONFIG_ONE_RESET = 16'h0000;
    // config two fields
    localparam int TRDIS_BIT = 0;
    localparam logic [31:0] CONFIG_TWO_RESET = 32'h0000_0000;
    localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;

    // descriptor layout: word 0 status, word 1 buffer address
    localparam int OWNER_BIT = 7;
    localparam int COUNT_LSB = 16;
    localparam int COUNT_W = 10;
    localparam int DESC_SHIFT = 3;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    // status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NOWN_BIT = 1;
    localparam int ST_IDX_LSB = 8;

    localparam int FIFO_DEPTH = 16;

    typedef logic [1:0] usbdm_mode_t;

    typedef struct packed {
        logic [3:0] endpoint;
        logic dir_in;
        logic odd;
    } usbdm_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } usbdm_dma_t;

    // descriptor index from endpoint, direction, even/odd and mode
    function automatic logic [5:0] desc_index(usbdm_mode_t mode,
                                              logic [3:0] ep,
                                              logic dir_in,
                                              logic odd);
        logic zero_ep;
        zero_ep = (ep == 4'h0);
        case (mode)
            2'd0: desc_index = {1'b0, ep, dir_in};
            2'd1: desc_index = zero_ep ? (dir_in ? 6'd2 : {5'd0, odd})
                                       : {1'b0, ep, dir_in} + 6'd1;
            2'd2: desc_index = {ep, dir_in, odd};
            default: desc_index = zero_ep ? {5'd0, dir_in}
                                          : {ep, dir_in, odd} - 6'd2;
        endcase
    endfunction

endpackage

// File: hdl/usbdm_fifo.sv
// parameterised fifo between the serial engine and the dma.
// assumes a single clock; write and read may happen in the same cycle.
`timescale 1ns/1ps
module usbdm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    always_comb
    begin
        in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
        out_valid = wr_ptr != rd_ptr;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + (AW + 1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW + 1)'(1) : rd_ptr;
        out_data = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage carries no reset so it maps onto plain ram
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// File: hdl/usbdm_top.sv
// usb descriptor dma: maps endpoint requests onto descriptor table entries,
// fetches them over a private dma master and moves buffer words.
// assumes ahb-lite single word transfers and a memory that acks each beat.
`timescale 1ns/1ps
module usbdm_top #(
    parameter int FIFO_DEPTH = usbdm_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sie_req_valid,
    output logic sie_req_ready,
    input wire usbdm_pkg::usbdm_req_t sie_req,
    output logic sie_done,
    output logic sie_not_owned,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [31:0] rx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [31:0] tx_data,
    output usbdm_pkg::usbdm_dma_t dma,
    input wire logic dma_ack,
    input wire logic [31:0] dma_rdata,
    input wire logic sys_idle,
    output logic eye_test_out,
    output logic oe_monitor_out
);
    typedef enum {S_IDLE, S_FETCH0, S_FETCH1, S_MOVE, S_WBACK, S_DONE}
        usbdm_state_t;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    logic wr_pend, next_wr_pend, next_eye, next_oemon;
    logic [7:0] wr_addr, next_wr_addr;
    logic [15:0] cfg1, next_cfg1;
    logic [31:0] cfg2, next_cfg2, tbl_base, next_tbl_base, next_hrdata;
    usbdm_state_t state, next_state;
    usbdm_pkg::usbdm_req_t cur, next_cur;
    usbdm_pkg::usbdm_dma_t next_dma;
    logic [5:0] idx, next_idx;
    logic [31:0] word0, next_word0, bufptr, next_bufptr;
    logic [usbdm_pkg::COUNT_W-1:0] remain, next_remain;
    logic not_owned, next_not_owned, next_done, next_ready, next_tx_valid;
    logic [31:0] next_tx_data, fifo_out_data;
    logic fifo_out_valid, fifo_out_ready, accept, hold, addr_ok, rx_push;
    logic [LW-1:0] rx_level, next_rx_level;
    usbdm_pkg::usbdm_mode_t mode;

    usbdm_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(rx_push),
        .in_ready(),
        .in_data(rx_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // mapping reads the live field, so a new mode applies to the next fetch
    assign mode = cfg1[usbdm_pkg::PINGPONG_LSB +: 2];
    assign hold = cfg1[usbdm_pkg::SIDL_BIT] && sys_idle;
    assign accept = sie_req_valid && sie_req_ready;
    assign rx_push = rx_valid && rx_ready;
    assign addr_ok = hsel && hready && htrans[1];

    // register file and ahb-lite slave: zero wait states, always okay
    always_comb
    begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        next_tbl_base = tbl_base;
        next_hrdata = hrdata;
        if (wr_pend)
        begin
            unique case (wr_addr)
                usbdm_pkg::OFS_CONFIG_ONE:
                    next_cfg1 = hwdata[15:0] & usbdm_pkg::CONFIG_ONE_MASK;
                usbdm_pkg::OFS_CONFIG_TWO:
                    next_cfg2 = {31'd0, hwdata[usbdm_pkg::TRDIS_BIT]};
                usbdm_pkg::OFS_TABLE_BASE: next_tbl_base = hwdata;
                default: ;
            endcase
        end
        if (addr_ok && !hwrite)
        begin
            unique case (haddr[7:0])
                usbdm_pkg::OFS_CONFIG_ONE: next_hrdata = {16'd0, cfg1};
                usbdm_pkg::OFS_CONFIG_TWO: next_hrdata = cfg2;
                usbdm_pkg::OFS_TABLE_BASE: next_hrdata = tbl_base;
                usbdm_pkg::OFS_STATUS:
                    next_hrdata = {18'd0, idx, 6'd0, not_owned,
                                   state != S_IDLE};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
        next_eye = next_cfg1[usbdm_pkg::EYE_BIT];
        // the monitor is meaningless while the on-chip transceiver drives
        next_oemon = next_cfg1[usbdm_pkg::OEMON_BIT]
                     && next_cfg2[usbdm_pkg::TRDIS_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            cfg1 <= usbdm_pkg::CONFIG_ONE_RESET;
            cfg2 <= usbdm_pkg::CONFIG_TWO_RESET;
            tbl_base <= usbdm_pkg::TABLE_BASE_RESET;
            hrdata <= 32'h0000_0000;
            eye_test_out <= 1'b0;
            oe_monitor_out <= 1'b0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            tbl_base <= next_tbl_base;
            hrdata <= next_hrdata;
            eye_test_out <= next_eye;
            oe_monitor_out <= next_oemon;
            hreadyout <= 1'b1;
        end
    end

    // descriptor engine: fetch, move buffer words, write back, report
    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_dma = dma;
        next_idx = idx;
        next_word0 = word0;
        next_bufptr = bufptr;
        next_remain = remain;
        next_not_owned = not_owned;
        next_tx_valid = tx_valid && !tx_ready;
        next_tx_data = tx_data;
        fifo_out_ready = 1'b0;
        unique case (state)
            S_IDLE:
                if (accept)
                begin
                    next_cur = sie_req;
                    next_idx = usbdm_pkg::desc_index(mode, sie_req.endpoint,
                        sie_req.dir_in, sie_req.odd);
                    next_dma.req = 1'b1;
                    next_dma.we = 1'b0;
                    next_dma.addr = tbl_base + {23'd0, next_idx, 3'd0};
                    next_state = S_FETCH0;
                end
            S_FETCH0:
                if (dma_ack)
                begin
                    next_word0 = dma_rdata;
                    next_dma.addr = dma.addr + usbdm_pkg::WORD_BYTES;
                    next_state = S_FETCH1;
                end
            S_FETCH1:
                if (dma_ack)
                begin
                    next_bufptr = dma_rdata;
                    next_remain = word0[usbdm_pkg::COUNT_LSB
                                        +: usbdm_pkg::COUNT_W];
                    // a cpu-owned entry is left untouched
                    next_not_owned = !word0[usbdm_pkg::OWNER_BIT];
                    next_dma.req = 1'b0;
                    next_state = word0[usbdm_pkg::OWNER_BIT] ? S_MOVE : S_DONE;
                end
            S_MOVE:
                if (dma.req)
                begin
                    if (dma_ack)
                    begin
                        next_dma.req = 1'b0;
                        next_bufptr = bufptr + usbdm_pkg::WORD_BYTES;
                        next_remain = remain - (usbdm_pkg::COUNT_W)'(1);
                        if (cur.dir_in)
                        begin
                            next_tx_valid = 1'b1;
                            next_tx_data = dma_rdata;
                        end
                    end
                end
                else if (remain == '0)
                begin
                    if (!next_tx_valid)
                    begin
                        // hand the entry back to the cpu
                        next_dma.req = 1'b1;
                        next_dma.we = 1'b1;
                        next_dma.addr = tbl_base + {23'd0, idx, 3'd0};
                        next_dma.wdata = word0;
                        next_dma.wdata[usbdm_pkg::OWNER_BIT] = 1'b0;
                        next_state = S_WBACK;
                    end
                end
                else if (!cur.dir_in && fifo_out_valid)
                begin
                    fifo_out_ready = 1'b1;
                    next_dma.req = 1'b1;
                    next_dma.we = 1'b1;
                    next_dma.addr = bufptr;
                    next_dma.wdata = fifo_out_data;
                end
                else if (cur.dir_in && !next_tx_valid)
                begin
                    next_dma.req = 1'b1;
                    next_dma.we = 1'b0;
                    next_dma.addr = bufptr;
                end
            S_WBACK:
                if (dma_ack)
                begin
                    next_dma.req = 1'b0;
                    next_dma.we = 1'b0;
                    next_state = S_DONE;
                end
            S_DONE: next_state = S_IDLE;
        endcase
        next_rx_level = rx_level + LW'(rx_push) - LW'(fifo_out_ready);
        next_done = next_state == S_DONE;
        next_ready = next_state == S_IDLE && !hold && !accept;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            cur <= '0;
            dma <= '0;
            idx <= 6'd0;
            word0 <= 32'h0000_0000;
            bufptr <= 32'h0000_0000;
            remain <= '0;
            not_owned <= 1'b0;
            sie_done <= 1'b0;
            sie_not_owned <= 1'b0;
            sie_req_ready <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 32'h0000_0000;
            rx_ready <= 1'b0;
            rx_level <= '0;
        end
        else
        begin
            state <= next_state;
            cur <= next_cur;
            dma <= next_dma;
            idx <= next_idx;
            word0 <= next_word0;
            bufptr <= next_bufptr;
            remain <= next_remain;
            not_owned <= next_not_owned;
            sie_done <= next_done;
            sie_not_owned <= next_done && next_not_owned;
            sie_req_ready <= next_ready;
            tx_valid <= next_tx_valid;
            tx_data <= next_tx_data;
            rx_level <= next_rx_level;
            // ready looks one word ahead so an offered word is never lost
            rx_ready <= next_rx_level != LW'(FIFO_DEPTH);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_eye_follows_cfg: assert property (
        wr_pend && wr_addr == usbdm_pkg::OFS_CONFIG_ONE
        |=> eye_test_out == $past(hwdata[usbdm_pkg::EYE_BIT]))
        else $error("eye test output does not follow written bit");
    a_upper_reads_zero: assert property (
        addr_ok && !hwrite && haddr[7:0] == usbdm_pkg::OFS_CONFIG_ONE
        |=> hrdata[31:8] == 24'd0 && hrdata[5] == 1'b0
            && hrdata[3:2] == 2'd0)
        else $error("unimplemented config bits read nonzero");
    a_oemon_gated: assert property (
        oe_monitor_out |-> cfg2[usbdm_pkg::TRDIS_BIT]
                           && cfg1[usbdm_pkg::OEMON_BIT])
        else $error("oe monitor active with transceiver enabled");
    a_mode_written: assert property (
        wr_pend && wr_addr == usbdm_pkg::OFS_CONFIG_ONE
        |=> mode == $past(hwdata[1:0]))
        else $error("ping-pong mode not taken from write");
    a_index_single: assert property (
        accept && !mode[1] && sie_req.endpoint != 4'h0
        |=> idx == 6'({$past(sie_req.endpoint), $past(sie_req.dir_in)})
                   + 6'($past(mode)) && dma.req && !dma.we
            && dma.addr == tbl_base + {23'd0, idx, 3'd0})
        else $error("single-buffer descriptor index wrong");
    a_index_pingpong: assert property (
        accept && mode[1] && sie_req.endpoint != 4'h0
        |=> idx == 6'({$past(sie_req.endpoint), $past(sie_req.dir_in),
                       $past(sie_req.odd)}) - 6'({$past(mode[0]), 1'b0}))
        else $error("ping-pong descriptor index wrong");
    a_dma_holds: assert property (
        dma.req && !dma_ack |=> dma.req && $stable(dma.addr)
                                && $stable(dma.we))
        else $error("dma request dropped before ack");
    a_cpu_owned_skip: assert property (
        state == S_FETCH1 && dma_ack && !word0[usbdm_pkg::OWNER_BIT]
        |=> state == S_DONE && !dma.req && sie_done && sie_not_owned)
        else $error("cpu-owned descriptor was processed");
    a_owner_released: assert property (
        state == S_WBACK && dma.req
        |-> dma.we && !dma.wdata[usbdm_pkg::OWNER_BIT])
        else $error("writeback keeps owner flag set");
endmodule

// File: testbench/usbdm_mem_model.sv
// system memory model for the descriptor dma: 512 words, ack after a wait.
// assumes one request at a time, held until it is acked.
`timescale 1ns/1ps
module usbdm_mem_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire usbdm_pkg::usbdm_dma_t dma,
    output logic dma_ack,
    output logic [31:0] dma_rdata,
    input wire logic [3:0] mem_wait
);
    // one contiguous region holds the table and the buffers
    logic [31:0] mem [512];
    logic [3:0] cnt;

    // read data toggles outside an ack so stale data never looks valid
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_ack <= 1'b0;
            cnt <= 4'h0;
            dma_rdata <= 32'h0000_0000;
        end
        else if (dma.req && !dma_ack && cnt == mem_wait)
        begin
            dma_ack <= 1'b1;
            cnt <= 4'h0;
            if (dma.we)
                mem[dma.addr[10:2]] <= dma.wdata;
            else
                dma_rdata <= mem[dma.addr[10:2]];
        end
        else
        begin
            dma_ack <= 1'b0;
            cnt <= (dma.req && !dma_ack) ? cnt + 4'h1 : 4'h0;
            dma_rdata <= ~dma_rdata;
        end
    end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for usbdm_top: registers, descriptor mapping,
// in and out transfers through the fifo and the memory model.
// assumes the memory model answers every dma request.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] ep;
        logic di;
        logic od;
        logic [5:0] idx;
    } usbdm_row_t;
    localparam logic [31:0] BASE = 32'h0000_0100;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rx_data = '0, tx_data;
    logic sie_req_valid = 1'b0, sie_req_ready, sie_done, sie_not_owned;
    usbdm_pkg::usbdm_req_t sie_req = '0;
    logic rx_valid = 1'b0, rx_ready, tx_valid, tx_ready = 1'b0;
    usbdm_pkg::usbdm_dma_t dma;
    logic [31:0] dma_rdata, rd, a;
    logic dma_ack, sys_idle = 1'b0, eye_test_out, oe_monitor_out, no, ok;
    logic [3:0] mem_wait = 4'h0;
    int fail_count = 0, tests_run = 0, pushed;
    logic [31:0] txq[$];
    usbdm_row_t rows [14] = '{
        '{2'h0, 4'h0, 1'b0, 1'b0, 6'h00}, '{2'h0, 4'hF, 1'b1, 1'b0, 6'h1F},
        '{2'h0, 4'h7, 1'b0, 1'b0, 6'h0E}, '{2'h1, 4'h0, 1'b0, 1'b1, 6'h01},
        '{2'h1, 4'h0, 1'b1, 1'b0, 6'h02}, '{2'h1, 4'h1, 1'b0, 1'b0, 6'h03},
        '{2'h1, 4'hF, 1'b1, 1'b0, 6'h20}, '{2'h2, 4'h0, 1'b1, 1'b1, 6'h03},
        '{2'h2, 4'h8, 1'b0, 1'b0, 6'h20}, '{2'h2, 4'hF, 1'b1, 1'b1, 6'h3F},
        '{2'h3, 4'h0, 1'b0, 1'b0, 6'h00}, '{2'h3, 4'h0, 1'b1, 1'b0, 6'h01},
        '{2'h3, 4'h1, 1'b0, 1'b0, 6'h02}, '{2'h3, 4'hF, 1'b1, 1'b1, 6'h3D}};

    assign hready = hreadyout;
    always #4 ref_clk = ~ref_clk;

    usbdm_top #(.FIFO_DEPTH(16)) usbdm_top_i (.ref_clk(ref_clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sie_req_valid(sie_req_valid), .sie_req_ready(sie_req_ready),
        .sie_req(sie_req), .sie_done(sie_done),
        .sie_not_owned(sie_not_owned), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .dma(dma),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .sys_idle(sys_idle),
        .eye_test_out(eye_test_out), .oe_monitor_out(oe_monitor_out));

    usbdm_mem_model usbdm_mem_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .dma(dma), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
        .mem_wait(mem_wait));

    // in-data sink stalls every other cycle
    always @(posedge ref_clk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            txq.push_back(tx_data);
        tx_ready <= ~tx_ready;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wait_rdy;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1)
            @(negedge ref_clk);
        rd = hrdata;
        @(posedge ref_clk);
    endtask

    // idle cycle after each transfer avoids the read-after-write hazard
    task ahb(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, ofs};
        hwrite <= w;
        wait_rdy;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy;
        @(posedge ref_clk);
    endtask

    task service(input logic [3:0] ep, input logic di, input logic od);
        logic got;
        got = 1'b0;
        sie_req <= '{ep, di, od};
        sie_req_valid <= 1'b1;
        @(negedge ref_clk);
        while (sie_req_ready !== 1'b1)
            @(negedge ref_clk);
        @(posedge ref_clk);
        sie_req_valid <= 1'b0;
        do
        begin
            @(negedge ref_clk);
            if (dma.req === 1'b1 && !got)
            begin
                a = dma.addr;
                got = 1'b1;
            end
        end
        while (sie_done !== 1'b1);
        no = sie_not_owned;
        @(posedge ref_clk);
    endtask

    task do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #100_000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end

    initial
    begin
        for (int k = 0; k < 512; k++)
            usbdm_mem_model_i.mem[k] = '0;
        do_reset;
        ahb(1'b1, usbdm_pkg::OFS_TABLE_BASE, BASE);
        foreach (rows[i])
        begin
            ahb(1'b1, usbdm_pkg::OFS_CONFIG_ONE, {30'h0, rows[i].mode});
            service(rows[i].ep, rows[i].di, rows[i].od);
            chk(a, BASE + {23'h0, rows[i].idx, 3'h0});
            chk({31'h0, no}, 32'h0000_0001);
        end
        // status keeps the last index and the cpu-owned outcome
        ahb(1'b0, usbdm_pkg::OFS_STATUS, '0);
        chk(rd, 32'h0000_3D02);
        chk({31'h0, hresp}, '0);
        $display("test mapping done");
        ahb(1'b1, usbdm_pkg::OFS_CONFIG_TWO, 32'h0000_0001);
        do_reset;
        // all registers reset to zero; offset 0x10 is unmapped
        for (int i = 0; i < 5; i++)
        begin
            ahb(1'b0, 8'(i * 4), '0);
            chk(rd, '0);
        end
        $display("test reset done");
        ahb(1'b1, usbdm_pkg::OFS_TABLE_BASE, BASE);
        ahb(1'b1, usbdm_pkg::OFS_CONFIG_ONE, 32'hFFFF_FFFF);
        ahb(1'b0, usbdm_pkg::OFS_CONFIG_ONE, '0);
        chk(rd, {16'h0000, usbdm_pkg::CONFIG_ONE_MASK});
        chk({31'h0, eye_test_out}, 32'h0000_0001);
        chk({31'h0, oe_monitor_out}, '0);
        ahb(1'b1, usbdm_pkg::OFS_CONFIG_TWO, 32'h0000_0001);
        chk({31'h0, oe_monitor_out}, 32'h0000_0001);
        sys_idle <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({31'h0, sie_req_ready}, '0);
        sys_idle <= 1'b0;
        ahb(1'b1, usbdm_pkg::OFS_CONFIG_ONE, '0);
        chk({31'h0, eye_test_out}, '0);
        chk({31'h0, oe_monitor_out}, '0);
        $display("test config done");
        // endpoint 2 in, mode 0: descriptor 5 owned, two words at 0x400
        mem_wait <= 4'h3;
        usbdm_mem_model_i.mem[74] = 32'h0002_0080;
        usbdm_mem_model_i.mem[75] = 32'h0000_0400;
        usbdm_mem_model_i.mem[256] = 32'hA5A5_0001;
        usbdm_mem_model_i.mem[257] = 32'hA5A5_0002;
        service(4'h2, 1'b1, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, no}, '0);
        chk(32'(txq.size()), 32'h0000_0002);
        chk(txq[0], 32'hA5A5_0001);
        chk(txq[1], 32'hA5A5_0002);
        chk(usbdm_mem_model_i.mem[74], 32'h0002_0000);
        $display("test in transfer done");
        rx_valid <= 1'b1;
        rx_data <= 32'h5A5A_0000;
        pushed = 0;
        do
        begin
            @(negedge ref_clk);
            ok = rx_ready;
            @(posedge ref_clk);
            if (ok === 1'b1)
            begin
                pushed++;
                rx_data <= 32'h5A5A_0000 + 32'(pushed);
            end
        end
        while (ok === 1'b1);
        rx_valid <= 1'b0;
        chk(32'(pushed), 32'h0000_0010);
        // endpoint 3 out: descriptor 6 drains sixteen words to 0x600
        usbdm_mem_model_i.mem[76] = 32'h0010_0080;
        usbdm_mem_model_i.mem[77] = 32'h0000_0600;
        service(4'h3, 1'b0, 1'b0);
        for (int k = 0; k < 16; k++)
            chk(usbdm_mem_model_i.mem[384 + k], 32'h5A5A_0000 + 32'(k));
        chk(usbdm_mem_model_i.mem[76], 32'h0010_0000);
        chk({31'h0, rx_ready}, 32'h0000_0001);
        $display("test out transfer done");
        test_done;
    end
endmodule
